// ==== core/bit_manip_regs.svh ====
// constants for the bit manipulation unit
`ifndef BIT_MANIP_REGS_SVH
`define BIT_MANIP_REGS_SVH
`define BMU_BYTE_W       8
`define BMU_POS_W        3
`define BMU_CARRY_RESET  1'h0
`define BMU_ZERO_RESET   1'h0
`define BMU_DATA_RESET   8'h00
`endif

// ==== core/bit_manip_pkg.sv ====
// types for the bit manipulation unit
package bit_manip_pkg;
  typedef enum logic [3:0] {
    op_set_single_bit        = 4'h0,
    op_clear_single_bit      = 4'h1,
    op_invert_single_bit     = 4'h2,
    op_test_single_bit       = 4'h3,
    op_carry_and_bit         = 4'h4,
    op_carry_and_inverted_bit = 4'h5,
    op_carry_or_bit          = 4'h6,
    op_carry_or_inverted_bit = 4'h7,
    op_carry_xor_bit         = 4'h8,
    op_carry_xor_inverted_bit = 4'h9
  } bit_op_t;
  typedef enum logic [2:0] {
    st_idle  = 3'b001,
    st_fetch = 3'b010,
    st_write = 3'b100
  } bmu_state_t;
endpackage

// ==== core/bit_select.sv ====
// one-hot mask and selected bit for a byte and bit position
`timescale 1ns/1ps
`include "bit_manip_regs.svh"
module bit_select (
  input  wire logic [`BMU_BYTE_W-1:0] data,
  input  wire logic [`BMU_POS_W-1:0]  pos,
  output logic      [`BMU_BYTE_W-1:0] mask,
  output logic                        bit_value
);
  // decode position into a one-hot mask
  genvar i;
  generate
    for (i = 0; i < `BMU_BYTE_W; i++) begin : g_mask
      assign mask[i] = (pos == `BMU_POS_W'(i));
    end
  endgenerate
  assign bit_value = |(data & mask);
endmodule // bit_select

// ==== core/bit_manipulation_unit.sv ====
// bit manipulation datapath of the 8-bit core
`timescale 1ns/1ps
`include "bit_manip_regs.svh"
module bit_manipulation_unit (
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  input  wire logic                        clk_en,
  input  wire logic                        start,
  input  wire bit_manip_pkg::bit_op_t      op,
  input  wire logic                        use_reg_pos,
  input  wire logic [`BMU_POS_W-1:0]       imm_pos,
  input  wire logic [`BMU_BYTE_W-1:0]      pos_reg,
  input  wire logic                        mem_operand,
  input  wire logic [`BMU_BYTE_W-1:0]      reg_operand,
  input  wire logic                        carry_in,
  output logic                             mem_read,
  input  wire logic                        mem_read_valid,
  input  wire logic [`BMU_BYTE_W-1:0]      mem_read_data,
  output logic                             mem_write,
  output logic      [`BMU_BYTE_W-1:0]      result,
  output logic                             reg_write,
  output logic                             carry_out,
  output logic                             carry_write,
  output logic                             zero_out,
  output logic                             zero_write,
  output logic                             busy,
  output logic                             done
);
  bit_manip_pkg::bmu_state_t state;
  bit_manip_pkg::bit_op_t    op_hold;
  logic [`BMU_POS_W-1:0]     pos_hold;
  logic [`BMU_BYTE_W-1:0]    operand;
  logic [`BMU_POS_W-1:0]     pos;
  logic [`BMU_BYTE_W-1:0]    mask;
  logic                      sel_bit;
  logic [`BMU_BYTE_W-1:0]    next_result;
  logic                      next_carry;
  logic                      is_carry_op;
  logic                      is_modify_op;
  bit_manip_pkg::bit_op_t    cur_op;
  logic [`BMU_POS_W-1:0]     want_pos;
  logic [`BMU_BYTE_W-1:0]    want_mask;

  // carry operations ignore the register position
  assign is_carry_op  = (op >= bit_manip_pkg::op_carry_and_bit);
  assign is_modify_op = (op_hold != bit_manip_pkg::op_test_single_bit)
                        && (op_hold < bit_manip_pkg::op_carry_and_bit);
  assign pos = (use_reg_pos && !is_carry_op) ? pos_reg[`BMU_POS_W-1:0]
                                             : imm_pos;
  assign operand = (state == bit_manip_pkg::st_fetch) ? mem_read_data : reg_operand;
  // operation in force: the held one while a memory byte is fetched
  assign cur_op  = (state == bit_manip_pkg::st_fetch) ? op_hold : op;

  bit_select u_sel (
    .data      (operand),
    .pos       ((state == bit_manip_pkg::st_fetch) ? pos_hold : pos),
    .mask      (mask),
    .bit_value (sel_bit)
  );

  // new byte and new carry for the current operation
  always_comb begin
    next_result = operand;
    next_carry  = carry_in;
    case (cur_op)
      bit_manip_pkg::op_set_single_bit:         next_result = operand | mask;
      bit_manip_pkg::op_clear_single_bit:       next_result = operand & ~mask;
      bit_manip_pkg::op_invert_single_bit:      next_result = operand ^ mask;
      bit_manip_pkg::op_carry_and_bit:          next_carry = carry_in & sel_bit;
      bit_manip_pkg::op_carry_and_inverted_bit: next_carry = carry_in & ~sel_bit;
      bit_manip_pkg::op_carry_or_bit:           next_carry = carry_in | sel_bit;
      bit_manip_pkg::op_carry_or_inverted_bit:  next_carry = carry_in | ~sel_bit;
      bit_manip_pkg::op_carry_xor_bit:          next_carry = carry_in ^ sel_bit;
      bit_manip_pkg::op_carry_xor_inverted_bit: next_carry = carry_in ^ ~sel_bit;
      default:                                  next_result = operand;
    endcase
  end

  // sequencer: register operands finish at once, memory ones read, then write back for set, clear and invert only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state    <= bit_manip_pkg::st_idle;
      op_hold  <= bit_manip_pkg::op_set_single_bit;
      pos_hold <= '0;
    end else if (clk_en) begin
      case (state)
        bit_manip_pkg::st_idle: begin
          if (start && mem_operand) begin
            state    <= bit_manip_pkg::st_fetch;
            op_hold  <= op;
            pos_hold <= pos;
          end
        end
        bit_manip_pkg::st_fetch: begin
          if (mem_read_valid) begin
            state <= is_modify_op ? bit_manip_pkg::st_write
                                  : bit_manip_pkg::st_idle;
          end
        end
        bit_manip_pkg::st_write: state <= bit_manip_pkg::st_idle;
        default:                 state <= bit_manip_pkg::st_idle;
      endcase
    end
  end

  // results and write strobes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      result      <= `BMU_DATA_RESET;
      carry_out   <= `BMU_CARRY_RESET;
      zero_out    <= `BMU_ZERO_RESET;
      reg_write   <= 1'b0;
      carry_write <= 1'b0;
      zero_write  <= 1'b0;
      done        <= 1'b0;
    end else if (clk_en) begin
      reg_write   <= 1'b0;
      carry_write <= 1'b0;
      zero_write  <= 1'b0;
      done        <= 1'b0;
      if ((state == bit_manip_pkg::st_idle && start && !mem_operand) ||
          (state == bit_manip_pkg::st_fetch && mem_read_valid)) begin
        done <= (state == bit_manip_pkg::st_idle) || !is_modify_op;
        if (cur_op == bit_manip_pkg::op_test_single_bit) begin
          zero_out   <= ~sel_bit;
          zero_write <= 1'b1;
        end else if (cur_op >= bit_manip_pkg::op_carry_and_bit) begin
          carry_out   <= next_carry;
          carry_write <= 1'b1;
        end else begin
          result    <= next_result;
          reg_write <= (state == bit_manip_pkg::st_idle);
        end
      end else if (state == bit_manip_pkg::st_write) begin
        done <= 1'b1;
      end
    end
  end

  // handshake outputs decoded straight from the state
  assign mem_read  = (state == bit_manip_pkg::st_fetch);
  assign mem_write = (state == bit_manip_pkg::st_write);
  assign busy      = (state != bit_manip_pkg::st_idle);

  // reference position and mask built from the request inputs, not from the datapath
  assign want_pos  = use_reg_pos ? pos_reg[`BMU_POS_W-1:0] : imm_pos;
  assign want_mask = `BMU_BYTE_W'(1) << want_pos;

  // register operand checks: one cycle from request to result
  a_test_no_write: assert property (@(posedge clk) disable iff (!reset_n)
    zero_write |-> !reg_write && !carry_write) else $error("test wrote data");
  a_set_bit_one: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && start && !busy && !mem_operand && op == bit_manip_pkg::op_set_single_bit)
    |=> result == ($past(reg_operand) | $past(want_mask))) else $error("set bit wrong");
  a_clear_bit_zero: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && start && !busy && !mem_operand && op == bit_manip_pkg::op_clear_single_bit)
    |=> result == ($past(reg_operand) & ~$past(want_mask))) else $error("clear bit wrong");
  a_invert_bit: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && start && !busy && !mem_operand && op == bit_manip_pkg::op_invert_single_bit)
    |=> result == ($past(reg_operand) ^ $past(want_mask))) else $error("invert bit wrong");
  a_test_zero_flag: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && start && !busy && !mem_operand && op == bit_manip_pkg::op_test_single_bit)
    |=> zero_write && !reg_write && zero_out == ~|($past(reg_operand) & $past(want_mask)))
    else $error("test bit wrong");

  // carry operations: the immediate always picks the bit
  a_carry_and: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && start && !busy && !mem_operand && op == bit_manip_pkg::op_carry_and_bit)
    |=> carry_write && carry_out == ($past(carry_in) & $past(reg_operand[imm_pos])))
    else $error("carry and wrong");
  a_carry_and_inv: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && start && !busy && !mem_operand
     && op == bit_manip_pkg::op_carry_and_inverted_bit)
    |=> carry_write && carry_out == ($past(carry_in) & ~$past(reg_operand[imm_pos])))
    else $error("inverted carry and wrong");
  a_carry_or: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && start && !busy && !mem_operand && op == bit_manip_pkg::op_carry_or_bit)
    |=> carry_write && carry_out == ($past(carry_in) | $past(reg_operand[imm_pos])))
    else $error("carry or wrong");
  a_carry_or_inv: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && start && !busy && !mem_operand
     && op == bit_manip_pkg::op_carry_or_inverted_bit)
    |=> carry_write && carry_out == ($past(carry_in) | ~$past(reg_operand[imm_pos])))
    else $error("inverted carry or wrong");
  a_carry_xor: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && start && !busy && !mem_operand && op == bit_manip_pkg::op_carry_xor_bit)
    |=> carry_write && carry_out == ($past(carry_in) ^ $past(reg_operand[imm_pos])))
    else $error("carry xor wrong");
  a_carry_xor_inv: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && start && !busy && !mem_operand
     && op == bit_manip_pkg::op_carry_xor_inverted_bit)
    |=> carry_write && carry_out == ($past(carry_in) ^ ~$past(reg_operand[imm_pos])))
    else $error("inverted carry xor wrong");
  a_carry_pos_imm: assert property (@(posedge clk) disable iff (!reset_n)
    is_carry_op |-> pos == imm_pos) else $error("carry op used register position");

  // memory modify steps: byte taken, one write cycle, then back to idle
  sequence s_mem_modify_taken;
    clk_en && mem_read && mem_read_valid && is_modify_op;
  endsequence
  sequence s_write_then_idle;
    mem_write ##1 !busy;
  endsequence
  a_mem_rmw_seq: assert property (@(posedge clk) disable iff (!reset_n)
    s_mem_modify_taken |=> s_write_then_idle)
    else $error("memory write back missing");
  a_write_one_cycle: assert property (@(posedge clk) disable iff (!reset_n)
    (mem_write && clk_en) |=> !mem_write) else $error("write stands too long");
  a_done_after_write: assert property (@(posedge clk) disable iff (!reset_n)
    (mem_write && clk_en) |=> done && !busy) else $error("done missing after write");
  a_mem_no_reg_write: assert property (@(posedge clk) disable iff (!reset_n)
    mem_write |-> !reg_write) else $error("memory write also wrote register");

  // a low clock enable holds every register where it is
  a_freeze_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !clk_en |=> $stable(state) && $stable(result) && $stable(carry_out) && $stable(done))
    else $error("state moved while frozen");
endmodule // bit_manipulation_unit

// ==== bench/bmu_mem_model.sv ====
// memory partner for the bit manipulation unit: slow or prompt read, byte write-back
`timescale 1ns/1ps
module bmu_mem_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       mem_read,
  input  wire logic       mem_write,
  input  wire logic [7:0] write_data,
  input  wire logic       load,
  input  wire logic [7:0] load_data,
  input  wire logic [3:0] wait_cycles,
  output logic            mem_read_valid,
  output logic [7:0]      mem_read_data,
  output logic [7:0]      stored
);
  logic [3:0] count;
  // answer a read wait_cycles plus one cycles after mem_read rises, with one cycle of valid data
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 4'h0;
      mem_read_valid <= 1'b0;
    end else begin
      mem_read_valid <= mem_read && !mem_read_valid && count == wait_cycles;
      count <= (mem_read && !mem_read_valid && count != wait_cycles) ? count + 4'h1 : 4'h0;
    end
  end
  // stored byte, preloaded by the bench or written back by the unit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) stored <= 8'h00;
    else if (mem_write) stored <= write_data;
    else if (load) stored <= load_data;
  end
  // outside the valid cycle the bus carries the inverse, never the stale byte
  assign mem_read_data = mem_read_valid ? stored : ~stored;
endmodule // bmu_mem_model

// ==== bench/test_bit_manipulation_unit.sv ====
// self-checking bench for the bit manipulation unit
`timescale 1ns/1ps
module test_bit_manipulation_unit;
  logic clk = 1'b0, reset_n = 1'b0, start = 1'b0, use_reg_pos = 1'b0, mem_operand = 1'b0;
  logic carry_in = 1'b0, load = 1'b0, clk_en = 1'b1, got_rw, got_mw;
  logic [3:0] wait_cycles = 4'h0;
  logic [2:0] imm_pos = 3'h0;
  logic [7:0] pos_reg = 8'h00, reg_operand = 8'h00, load_data = 8'h00, wr;
  logic [7:0] mem_read_data, result, stored;
  logic mem_read, mem_read_valid, mem_write, reg_write, carry_out, carry_write;
  logic zero_out, zero_write, busy, done;
  bit_manip_pkg::bit_op_t op = bit_manip_pkg::op_set_single_bit;
  int err_total = 0, compares = 0;
  bit_manipulation_unit bit_manipulation_unit_inst (.clk, .reset_n, .clk_en, .start, .op,
    .use_reg_pos, .imm_pos, .pos_reg, .mem_operand, .reg_operand, .carry_in, .mem_read,
    .mem_read_valid, .mem_read_data, .mem_write, .result, .reg_write, .carry_out,
    .carry_write, .zero_out, .zero_write, .busy, .done);
  bmu_mem_model bmu_mem_model_inst (.clk, .reset_n, .mem_read, .mem_write,
    .write_data(result), .load, .load_data, .wait_cycles, .mem_read_valid, .mem_read_data,
    .stored);
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one request, then collect strobes until done under a bounded wait
  task automatic do_op(input logic [3:0] k, input logic ur, mo, input logic [2:0] ip,
                       input logic [7:0] pr, opd, input logic c);
    int i;
    @(posedge clk);
    op <= bit_manip_pkg::bit_op_t'(k);
    use_reg_pos <= ur;
    mem_operand <= mo;
    imm_pos <= ip;
    pos_reg <= pr;
    reg_operand <= opd;
    carry_in <= c;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    got_rw = 1'b0;
    got_mw = 1'b0;
    for (i = 0; i < 40; i++) begin
      #1;
      if (reg_write === 1'b1) got_rw = 1'b1;
      if (mem_write === 1'b1) got_mw = 1'b1;
      if (mem_write === 1'b1) wr = result;
      if (done === 1'b1) break;
      @(posedge clk);
    end
    if (i == 40) begin
      err_total++;
      tally_and_finish;
    end
  endtask
  function automatic logic [7:0] modify(input logic [3:0] k, input logic [7:0] v, p);
    case (k)
      4'h0: return v | (8'h01 << p[2:0]);
      4'h1: return v & ~(8'h01 << p[2:0]);
      default: return v ^ (8'h01 << p[2:0]);
    endcase
  endfunction
  function automatic logic [7:0] flag_exp(input logic [3:0] k, input logic c, b);
    case (k)
      4'h3: return {7'h00, !b};
      4'h4: return {7'h00, c & b};
      4'h5: return {7'h00, c & !b};
      4'h6: return {7'h00, c | b};
      4'h7: return {7'h00, c | !b};
      4'h8: return {7'h00, c ^ b};
      default: return {7'h00, c ^ !b};
    endcase
  endfunction
  // set, clear, invert on a register, position alternately immediate and register
  task automatic t_modify_reg;
    for (int k = 0; k < 3; k++) begin
      for (int p = 0; p < 8; p++) begin
        do_op(k[3:0], p[0], 1'b0, p[2:0], {5'h15, ~p[2:0]}, 8'hA5, 1'b0);
        check(result, modify(k[3:0], 8'hA5, p[0] ? {5'h00, ~p[2:0]} : p));
        check({7'h00, got_rw}, 8'h01);
      end
    end
  endtask
  // test and all six carry ops; register position given but must be ignored for carry
  task automatic t_test_carry;
    logic [2:0] ps;
    for (int k = 3; k < 10; k++) begin
      for (int p = 0; p < 8; p += 3) begin
        for (int c = 0; c < 2; c++) begin
          ps = (k == 3) ? ~p[2:0] : p[2:0];
          do_op(k[3:0], 1'b1, 1'b0, p[2:0], {5'h0A, ~p[2:0]}, 8'h5A, c[0]);
          check({7'h00, k == 3 ? zero_out : carry_out}, flag_exp(k[3:0], c[0], 8'h5A >> ps));
          check({6'h00, carry_write, zero_write | got_rw}, k == 3 ? 8'h01 : 8'h02);
        end
      end
    end
  endtask
  // memory operands: slow and prompt reads, read-modify-write of the whole byte
  task automatic t_memory;
    @(posedge clk);
    load_data <= 8'h0F;
    load <= 1'b1;
    wait_cycles <= 4'h3;
    @(posedge clk);
    load <= 1'b0;
    do_op(4'h0, 1'b0, 1'b1, 3'h6, 8'h00, 8'h00, 1'b0);
    check({wr[7:1], got_rw | ~got_mw}, 8'h4E);
    wait_cycles <= 4'h0;
    do_op(4'h2, 1'b1, 1'b1, 3'h5, 8'hF0, 8'h00, 1'b0);
    check(stored, 8'h4E);
    do_op(4'h3, 1'b0, 1'b1, 3'h6, 8'h00, 8'h00, 1'b0);
    check({6'h00, got_mw, zero_out}, 8'h00);
    do_op(4'h9, 1'b0, 1'b1, 3'h0, 8'h00, 8'h00, 1'b0);
    check({6'h00, got_mw, carry_out}, 8'h01);
  endtask
  // clock enable low: a standing request is not taken; it is dropped as enable returns, then issued again
  task automatic t_freeze;
    @(posedge clk);
    clk_en <= 1'b0;
    op <= bit_manip_pkg::op_set_single_bit;
    use_reg_pos <= 1'b0;
    mem_operand <= 1'b0;
    imm_pos <= 3'h7;
    reg_operand <= 8'h00;
    start <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check({5'h00, busy, reg_write, done}, 8'h00);
    @(posedge clk);
    start <= 1'b0;
    clk_en <= 1'b1;
    do_op(4'h0, 1'b0, 1'b0, 3'h7, 8'h00, 8'h00, 1'b0);
    check(result, 8'h80);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    check({busy, done, reg_write, mem_write, carry_write, zero_write, 2'h0}, 8'h00);
    t_modify_reg;
    t_test_carry;
    t_memory;
    t_freeze;
    tally_and_finish;
  end
endmodule // test_bit_manipulation_unit
